//--- src/iopc_defines.svh
`ifndef IOPC_DEFINES_SVH
`define IOPC_DEFINES_SVH
// ==========================================================================
// Register offsets and reset values
`define IOPC_ADDR_INC      5'h19
`define IOPC_ADDR_MASK     5'h1A
`define IOPC_ADDR_PWM      5'h1B
`define IOPC_INC_RST       24'h081024
`define IOPC_MASK_RST      24'h000000
`define IOPC_PWM_RST       24'h670100
`define IOPC_MASK_WMASK    24'hDFFFFF
// ==========================================================================
// Incremental output control fields
`define IOPC_SLEW_HI       21
`define IOPC_SLEW_LO       16
`define IOPC_INVERT        15
`define IOPC_HYST_EN       12
`define IOPC_IDX_HI        9
`define IOPC_IDX_LO        8
`define IOPC_OSC_HIGH      7
`define IOPC_LOCK_HIGH     6
`define IOPC_OUT_EN        5
`define IOPC_COMM_SEL      4
`define IOPC_RES_HI        3
`define IOPC_RES_LO        0
// ==========================================================================
// PWM control fields and error flag positions
`define IOPC_PWM_EN        23
`define IOPC_BAND_HI       22
`define IOPC_BAND_LO       20
`define IOPC_FREQ_HI       19
`define IOPC_FREQ_LO       16
`define IOPC_ERR_OSC       4
`define IOPC_ERR_LOCK      7
// ==========================================================================
// Timing
`define IOPC_CLK_PERIOD_NS 20
`define IOPC_SLEW_UNIT_NS  125
`define IOPC_SYS_CLK_HZ    50000000
`endif

//--- src/iopc_pkg.sv
// ==========================================================================
// Types of the incremental and PWM output stage
package iopc_pkg;
    // Output pin function, one-hot.
    typedef enum logic [2:0] {
        IOPC_OFF  = 3'b001,
        IOPC_QUAD = 3'b010,
        IOPC_COMM = 3'b100
    } iopc_mode_t;

    // Whole register state of the block.
    typedef struct packed {
        logic [23:0] inc;
        logic [23:0] mask;
        logic [23:0] pwm_ctl;
        logic [23:0] rdata;
        logic [13:0] hold;
        logic [15:0] pos;
        logic [12:0] slew_cnt;
        logic [18:0] period;
        logic [18:0] pwm_cnt;
        logic        a;
        logic        b;
        logic        i;
        logic        oe;
        logic        err;
        logic        pwm;
        logic        pwm_oe;
    } iopc_state_t;
endpackage

//--- src/iopc_top.sv
`timescale 1ns/1ps
`include "iopc_defines.svh"
module iopc_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    // Register port
    input  wire logic        REG_WR,
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [23:0] REG_WDATA,
    output logic      [23:0] REG_RDATA,
    // Angle path, PWM duty and error flags
    input  wire logic [13:0] ANGLE,
    input  wire logic [5:0]  HYST_THRESH,
    input  wire logic [11:0] PWM_DUTY,
    input  wire logic [23:0] ERR_FLAGS,
    // Encoder and commutation pins
    output logic             OUT_A,
    output logic             OUT_B,
    output logic             OUT_I,
    output logic             OUT_OE,
    // Summary error and PWM pin
    output logic             SUMMARY_ERR,
    output logic             PWM_OUT,
    output logic             PWM_OE
);
    // ======================================================================
    // Carrier frequency table in Hz, indexed step*8+band.
    localparam logic [11:0] FREQ_LUT [0:127] = '{
        12'd3125,12'd2778,12'd2273,12'd1667,12'd1087,12'd641,12'd352,12'd185,
        12'd3101,12'd2740,12'd2222,12'd1613,12'd1042,12'd610,12'd333,12'd175,
        12'd3077,12'd2703,12'd2174,12'd1563,12'd1000,12'd581,12'd316,12'd166,
        12'd3053,12'd2667,12'd2128,12'd1515,12'd962,12'd556,12'd301,12'd157,
        12'd3030,12'd2632,12'd2083,12'd1471,12'd926,12'd532,12'd287,12'd150,
        12'd3008,12'd2597,12'd2041,12'd1429,12'd893,12'd510,12'd275,12'd143,
        12'd2985,12'd2564,12'd2000,12'd1389,12'd862,12'd490,12'd263,12'd137,
        12'd2963,12'd2532,12'd1961,12'd1351,12'd833,12'd472,12'd253,12'd131,
        12'd2941,12'd2500,12'd1923,12'd1316,12'd806,12'd455,12'd243,12'd126,
        12'd2920,12'd2469,12'd1887,12'd1282,12'd781,12'd439,12'd234,12'd121,
        12'd2899,12'd2439,12'd1852,12'd1250,12'd758,12'd424,12'd225,12'd116,
        12'd2878,12'd2410,12'd1818,12'd1220,12'd735,12'd410,12'd217,12'd112,
        12'd2857,12'd2381,12'd1786,12'd1190,12'd714,12'd397,12'd210,12'd108,
        12'd2837,12'd2353,12'd1754,12'd1163,12'd694,12'd385,12'd203,12'd105,
        12'd2817,12'd2326,12'd1724,12'd1136,12'd676,12'd373,12'd197,12'd101,
        12'd2797,12'd2299,12'd1695,12'd1111,12'd658,12'd362,12'd191,12'd98
    };

    iopc_pkg::iopc_state_t st;
    iopc_pkg::iopc_state_t nxt;
    iopc_pkg::iopc_mode_t  mode;
    logic [5:0]  slew_n;
    logic [12:0] slew_lim;
    logic [3:0]  res;
    logic [3:0]  res_q;
    logic [15:0] target;
    logic [15:0] pmask;
    logic [15:0] diff;
    logic [13:0] hdiff;
    logic [13:0] hmag;
    logic [13:0] elec;
    logic [16:0] sect6;
    logic        fault;
    logic        idx_hit;
    logic [2:0]  pins;
    logic [11:0] freq_hz;
    logic [30:0] duty_thr;

    // ======================================================================
    // Field decode and derived figures.
    assign slew_n = st.inc[`IOPC_SLEW_HI:`IOPC_SLEW_LO];
    assign res    = st.inc[`IOPC_RES_HI:`IOPC_RES_LO];
    // Least spacing rounds up to whole clock cycles.
    assign slew_lim = 13'(((32'(slew_n) + 32'd1) * `IOPC_SLEW_UNIT_NS
                      + `IOPC_CLK_PERIOD_NS - 1) / `IOPC_CLK_PERIOD_NS);
    // Reserved quadrature codes are clamped to the nearest legal one.
    assign res_q  = (res < 4'h3) ? 4'h3 : ((res == 4'hF) ? 4'hE : res);
    assign target = 16'({2'b00, st.hold} >> (res_q - 4'h2));
    assign pmask  = 16'hFFFF >> res_q;
    assign diff   = (target - st.pos) & pmask;
    assign hdiff  = ANGLE - st.hold;
    assign hmag   = hdiff[13] ? 14'(-hdiff) : hdiff;
    assign elec   = 14'(st.hold * (5'(res) + 5'h01));
    assign sect6  = 17'(elec * 3'd6);
    assign fault  = (st.inc[`IOPC_OSC_HIGH] & ERR_FLAGS[`IOPC_ERR_OSC]) |
                    (st.inc[`IOPC_LOCK_HIGH] & ERR_FLAGS[`IOPC_ERR_LOCK]);
    assign freq_hz = FREQ_LUT[{st.pwm_ctl[`IOPC_FREQ_HI:`IOPC_FREQ_LO],
                               st.pwm_ctl[`IOPC_BAND_HI:`IOPC_BAND_LO]}];
    assign duty_thr = 31'(st.period * PWM_DUTY) >> 12;

    // ======================================================================
    // Pin function select.
    always_comb begin
        if (!st.inc[`IOPC_OUT_EN]) begin
            mode = iopc_pkg::IOPC_OFF;
        end else if (st.inc[`IOPC_COMM_SEL]) begin
            mode = iopc_pkg::IOPC_COMM;
        end else begin
            mode = iopc_pkg::IOPC_QUAD;
        end
    end

    // Index window around position zero, R being one quadrature state.
    always_comb begin
        case (st.inc[`IOPC_IDX_HI:`IOPC_IDX_LO])
            2'd0: idx_hit = (st.pos == 16'h0000);
            2'd1: idx_hit = (st.pos == 16'h0000) || (st.pos == pmask);
            2'd2: idx_hit = (st.pos <= 16'h0001) || (st.pos == pmask);
            default: idx_hit = (st.pos <= 16'h0001) || (st.pos == pmask) ||
                               (st.pos == pmask - 16'h0001);
        endcase
    end

    // Raw pin levels before inversion.
    always_comb begin
        case (mode)
            iopc_pkg::IOPC_QUAD: begin
                pins = {st.pos[1], st.pos[1] ^ st.pos[0], idx_hit};
                if (fault) begin
                    pins = 3'b111;
                end
            end
            iopc_pkg::IOPC_COMM: begin
                case (sect6[16:14])
                    3'd0: pins = 3'b100;
                    3'd1: pins = 3'b110;
                    3'd2: pins = 3'b010;
                    3'd3: pins = 3'b011;
                    3'd4: pins = 3'b001;
                    default: pins = 3'b101;
                endcase
            end
            default: pins = 3'b000;
        endcase
    end

    // ======================================================================
    // Next-state logic for the whole block.
    always_comb begin
        nxt = st;
        // Configuration writes; the reserved mask bit never stores.
        if (REG_WR) begin
            case (REG_ADDR)
                `IOPC_ADDR_INC: nxt.inc = REG_WDATA;
                `IOPC_ADDR_MASK: nxt.mask = REG_WDATA & `IOPC_MASK_WMASK;
                `IOPC_ADDR_PWM: nxt.pwm_ctl = REG_WDATA;
                default: ;
            endcase
        end
        // Read data is registered; unmapped offsets read as zero.
        case (REG_ADDR)
            `IOPC_ADDR_INC: nxt.rdata = st.inc;
            `IOPC_ADDR_MASK: nxt.rdata = st.mask;
            `IOPC_ADDR_PWM: nxt.rdata = st.pwm_ctl;
            default: nxt.rdata = 24'h000000;
        endcase
        if (!st.inc[`IOPC_HYST_EN] || hmag > 14'(HYST_THRESH)) begin
            nxt.hold = ANGLE;
        end
        if (slew_n == 6'h00) begin
            nxt.pos      = target;
            nxt.slew_cnt = 13'h0000;
        end else if (st.slew_cnt != 13'h0000) begin
            nxt.slew_cnt = st.slew_cnt - 13'h0001;
        end else if (diff != 16'h0000) begin
            // Each step reloads the spacing count, so steps never bunch.
            // Shortest way round; a half-turn jump steps downward.
            if (diff <= (pmask >> 1)) begin
                nxt.pos = (st.pos + 16'h0001) & pmask;
            end else begin
                nxt.pos = (st.pos - 16'h0001) & pmask;
            end
            nxt.slew_cnt = slew_lim - 13'h0001;
        end
        nxt.a  = pins[2] ^ (st.inc[`IOPC_INVERT] &
                            (mode != iopc_pkg::IOPC_OFF));
        nxt.b  = pins[1] ^ (st.inc[`IOPC_INVERT] &
                            (mode != iopc_pkg::IOPC_OFF));
        nxt.i  = pins[0] ^ (st.inc[`IOPC_INVERT] &
                            (mode != iopc_pkg::IOPC_OFF));
        nxt.oe = (mode != iopc_pkg::IOPC_OFF);
        nxt.err = |(ERR_FLAGS & ~st.mask & `IOPC_MASK_WMASK);
        nxt.period = 19'(`IOPC_SYS_CLK_HZ / 32'(freq_hz));
        nxt.pwm_oe = st.pwm_ctl[`IOPC_PWM_EN];
        if (!st.pwm_ctl[`IOPC_PWM_EN]) begin
            nxt.pwm_cnt = 19'h00000;
            nxt.pwm     = 1'b0;
        end else begin
            if (st.pwm_cnt + 19'h00001 >= st.period) begin
                nxt.pwm_cnt = 19'h00000;
            end else begin
                nxt.pwm_cnt = st.pwm_cnt + 19'h00001;
            end
            nxt.pwm = (31'(st.pwm_cnt) < duty_thr);
        end
    end

    // ======================================================================
    // State register.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st          <= '0;
            st.inc      <= `IOPC_INC_RST;
            st.mask     <= `IOPC_MASK_RST;
            st.pwm_ctl  <= `IOPC_PWM_RST;
            st.period   <= 19'h00001;
        end else begin
            st <= nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign REG_RDATA   = st.rdata;
    assign OUT_A       = st.a;
    assign OUT_B       = st.b;
    assign OUT_I       = st.i;
    assign OUT_OE      = st.oe;
    assign SUMMARY_ERR = st.err;
    assign PWM_OUT     = st.pwm;
    assign PWM_OE      = st.pwm_oe;

    // ======================================================================
    // Checks on the block's own behaviour.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_pos_step;
        $changed(st.pos) && slew_n != 6'h00;
    endsequence
    property p_edge_spacing;
        s_pos_step |=> $stable(st.pos) [*8];
    endproperty
    a_edge_spacing: assert property (p_edge_spacing)
        else $error("Quadrature edges closer than slew limit.");

    // Only slewed steps are single; a slew-free jump may skip states.
    property p_gray_step;
        mode == iopc_pkg::IOPC_QUAD && slew_n != 6'h00 && !fault &&
            !$past(fault) && $stable(st.inc) && $stable(mode)
            ##1 $changed({st.a, st.b}) && $stable(st.inc)
            |-> $countones({st.a, st.b} ^ $past({st.a, st.b})) == 1;
    endproperty
    a_gray_step: assert property (p_gray_step)
        else $error("Quadrature step changed both lines.");

    property p_hyst_hold;
        st.inc[`IOPC_HYST_EN] && hmag <= 14'(HYST_THRESH)
            |=> $stable(st.hold);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold)
        else $error("Held angle moved inside hysteresis band.");

    property p_index_zero;
        mode == iopc_pkg::IOPC_QUAD && !fault && !st.inc[`IOPC_INVERT] &&
            st.inc[`IOPC_IDX_HI:`IOPC_IDX_LO] == 2'd0 && st.pos != 16'h0000
            |=> !st.i;
    endproperty
    a_index_zero: assert property (p_index_zero)
        else $error("Index active away from position zero.");

    property p_osc_high;
        mode == iopc_pkg::IOPC_QUAD && st.inc[`IOPC_OSC_HIGH] &&
            ERR_FLAGS[`IOPC_ERR_OSC] && !st.inc[`IOPC_INVERT]
            |=> st.a && st.b && st.i;
    endproperty
    a_osc_high: assert property (p_osc_high)
        else $error("Oscillator fault did not force outputs high.");

    property p_lock_inverted;
        mode == iopc_pkg::IOPC_QUAD && st.inc[`IOPC_LOCK_HIGH] &&
            ERR_FLAGS[`IOPC_ERR_LOCK] && st.inc[`IOPC_INVERT]
            |=> !st.a && !st.b && !st.i;
    endproperty
    a_lock_inverted: assert property (p_lock_inverted)
        else $error("Inverted lock-loss level is not all low.");

    property p_pins_off;
        !st.inc[`IOPC_OUT_EN] |=> !OUT_OE && !st.a && !st.b && !st.i;
    endproperty
    a_pins_off: assert property (p_pins_off)
        else $error("Encoder pins active while disabled.");

    property p_comm_pattern;
        mode == iopc_pkg::IOPC_COMM
            |=> OUT_OE && (st.a | st.b | st.i) && !(st.a & st.b & st.i);
    endproperty
    a_comm_pattern: assert property (p_comm_pattern)
        else $error("Commutation output in illegal pattern.");

    property p_mask_error;
        (ERR_FLAGS & ~st.mask & `IOPC_MASK_WMASK) == 24'h000000
            |=> !st.err;
    endproperty
    a_mask_error: assert property (p_mask_error)
        else $error("Masked error reached summary bit.");

    property p_pwm_off;
        !st.pwm_ctl[`IOPC_PWM_EN] |=> !PWM_OE && !PWM_OUT;
    endproperty
    a_pwm_off: assert property (p_pwm_off)
        else $error("PWM pin driven while disabled.");

    property p_pins_on;
        st.inc[`IOPC_OUT_EN] |=> OUT_OE;
    endproperty
    a_pins_on: assert property (p_pins_on)
        else $error("Encoder pins idle while enabled.");

    property p_mask_reserved;
        !st.mask[21];
    endproperty
    a_mask_reserved: assert property (p_mask_reserved)
        else $error("Reserved mask bit holds a one.");
endmodule

//--- dv/iopc_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host side decoder watching the quadrature pins
module iopc_host_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clr,
    // Encoder pins
    input  wire logic        a,
    input  wire logic        b,
    // Decoder results
    output logic [15:0]      min_gap,
    output logic [7:0]       bad
);
    logic [1:0]  last_ab;
    logic [15:0] gap;

    // Tracks edge spacing and flags steps that move both lines at once.
    // spacing, one line a step
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ab <= 2'b00;
            gap     <= 16'hFFFF;
            min_gap <= 16'hFFFF;
            bad     <= 8'h00;
        end else if (clr) begin
            last_ab <= {a, b};
            gap     <= 16'hFFFF;
            min_gap <= 16'hFFFF;
            bad     <= 8'h00;
        end else if ({a, b} != last_ab) begin
            last_ab <= {a, b};
            gap     <= 16'h0000;
            if (gap + 16'h0001 < min_gap && gap != 16'hFFFF) begin
                min_gap <= gap + 16'h0001;
            end
            if ({a, b} == ~last_ab) begin
                bad <= bad + 8'h01;
            end
        end else if (gap != 16'hFFFF) begin
            gap <= gap + 16'h0001;
        end
    end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "iopc_defines.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        clr = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [23:0] wdata = 24'h000000;
    logic [23:0] err = 24'h000000;
    logic [13:0] ang = 14'h0000;
    logic [5:0]  hyst = 6'h00;
    logic [11:0] duty = 12'h800;
    logic [23:0] rdata;
    logic        oa, ob, oi, ooe, serr, pwm, poe, v;
    logic [15:0] mgap;
    logic [7:0]  bad;
    logic [31:0] seed = 32'h00009932;
    logic [31:0] r;
    logic [13:0] a;
    int          errors = 0;
    int          checks = 0;
    int          n, e, p, h, l;

    always #10 clk = ~clk;

    iopc_top u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .REG_WR(wr),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .ANGLE(ang),
        .HYST_THRESH(hyst), .PWM_DUTY(duty), .ERR_FLAGS(err), .OUT_A(oa),
        .OUT_B(ob), .OUT_I(oi), .OUT_OE(ooe), .SUMMARY_ERR(serr),
        .PWM_OUT(pwm), .PWM_OE(poe));
    iopc_host_model u_host (.clk(clk), .rst_n(rst_n), .clr(clr), .a(oa),
        .b(ob), .min_gap(mgap), .bad(bad));

    // ======================================================================
    // Expectation helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [23:0] incw(logic [5:0] s, logic iv, logic hy,
        logic [1:0] x, logic [1:0] f, logic oe, logic u, logic [3:0] rs);
        return {2'h0, s, iv, 2'h0, hy, 2'h0, x, f, oe, u, rs};
    endfunction

    // Gray order of the four states, complemented when inverted.
    function automatic logic [1:0] quad(logic [1:0] q, logic iv);
        return {q[1], q[1] ^ q[0]} ^ {2{iv}};
    endfunction

    function automatic logic [2:0] comm_pins(int ang_v, int rs);
        logic [17:0] tbl;
        int          s;
        tbl = 18'b100110010011001101;
        s = 6 * ((ang_v * (rs + 1)) % 16384) / 16384;
        return tbl[17 - 3 * s -: 3];
    endfunction

    // ======================================================================
    // Bus and compare tasks
    task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic cyc(int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wreg(logic [4:0] ad, logic [23:0] d);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask

    task automatic rreg(logic [4:0] ad, logic [23:0] exp);
        addr = ad;
        cyc(2);
        cmp("reg", exp, rdata);
    endtask

    // Counts cycles while the carrier stays at one level, bounded.
    task automatic run(logic lvl, output int c);
        c = 0;
        while (pwm === lvl && c < 40000) begin
            cyc(1);
            c++;
        end
    endtask

    // Skips the partial phases so a stale period after a change is ignored.
    task automatic pwm_chk(logic [23:0] cfg, int per);
        wreg(5'h1B, cfg);
        cyc(1);
        cmp("pwm_oe", 24'h1, poe);
        run(1'b1, h);
        run(1'b0, h);
        run(1'b1, h);
        run(1'b0, l);
        cmp("pwm_period", per, h + l);
        cmp("pwm_high", per / 2, h);
    endtask

    task automatic end_of_test();
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Watchdog, sized well past the carrier measurements.
    initial begin
        #2500000;
        errors++;
        end_of_test();
    end

    // ======================================================================
    // Main sequence
    initial begin
        cyc(5);
        rst_n = 1'b1;
        rreg(5'h19, `IOPC_INC_RST);
        rreg(5'h1A, `IOPC_MASK_RST);
        rreg(5'h1B, `IOPC_PWM_RST);
        rreg(5'h05, 24'h000000);
        wreg(5'h1A, 24'hFFFFFF);
        rreg(5'h1A, 24'hDFFFFF);
        for (int k = 0; k < 20; k++) begin
            r = rnd();
            wreg(5'h1A, r[23:0]);
            err = rnd();
            cyc(2);
            cmp("sum_err", |(err & ~r[23:0] & 24'hDFFFFF), serr);
        end
        err = 24'h000000;
        // Random resolution, angle and inversion with slew off.
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            n = r[3:0];
            a = r[17:4];
            v = r[18];
            wreg(5'h19, incw(6'h00, v, 1'b0, 2'h0, 2'h0, 1'b1, 1'b0, n[3:0]));
            ang = a;
            cyc(5);
            e = (n < 3) ? 3 : (n == 15) ? 14 : n;
            p = a >> (e - 2);
            cmp("ab", quad(p[1:0], v), {oa, ob});
            cmp("idx", (p == 0) ^ v, oi);
        end
        for (int m = 0; m < 4; m++) begin
            wreg(5'h19, incw(6'h00, 1'b0, 1'b0, m[1:0], 2'h0, 1'b1, 1'b0, 4'hC));
            for (int d = -2; d <= 2; d++) begin
                ang = 14'(d * 1024 + 512);
                cyc(5);
                cmp("idx_mode", d >= -(m + 1) / 2 && d <= m / 2, oi);
            end
        end
        // Each fault source forces the pins to the fault level (high, or low when inverted) only with its own enable.
        for (int k = 0; k < 4; k++) begin
            wreg(5'h19, incw(6'h00, k[0], 1'b0, 2'h0, k[1] ? 2'h2 : 2'h1,
                1'b1, 1'b0, 4'hC));
            ang = 14'h0200;
            err = k[1] ? 24'h000010 : 24'h000080;
            cyc(3);
            cmp("fault", {3{~k[0]}}, {oa, ob, oi});
            err = k[1] ? 24'h000080 : 24'h000010;
            cyc(3);
            cmp("no_fault", 3'b001 ^ {3{k[0]}}, {oa, ob, oi});
        end
        err = 24'h000000;
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            n = r[3:0];
            a = r[17:4];
            v = r[18];
            wreg(5'h19, incw(6'h00, v, 1'b0, 2'h0, 2'h0, 1'b1, 1'b1, n[3:0]));
            ang = a;
            cyc(5);
            cmp("comm", comm_pins(a, n) ^ {3{v}}, {oa, ob, oi});
        end
        cmp("oe_on", 24'h1, ooe);
        wreg(5'h19, incw(6'h00, 1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 4'hC));
        cyc(5);
        cmp("off", 24'h0, {ooe, oa, ob, oi});
        // Small moves inside the threshold must not reach the pins.
        hyst = 6'h08;
        ang = 14'h03FE;
        wreg(5'h19, incw(6'h00, 1'b0, 1'b1, 2'h0, 2'h0, 1'b1, 1'b0, 4'hC));
        cyc(5);
        ang = 14'h0402;
        cyc(5);
        cmp("hyst_hold", 2'b00, {oa, ob});
        ang = 14'h0410;
        cyc(5);
        cmp("hyst_move", 2'b01, {oa, ob});
        hyst = 6'h00;
        ang = 14'h0200;
        wreg(5'h19, incw(6'h03, 1'b0, 1'b0, 2'h0, 2'h0, 1'b1, 1'b0, 4'hC));
        clr = 1'b1;
        cyc(5);
        clr = 1'b0;
        ang = 14'h1E00;
        cyc(220);
        cmp("slew_end", quad(2'h3, 1'b0), {oa, ob});
        cmp("slew_gap", 24'h1, mgap >= 16'd25 && mgap != 16'hFFFF);
        cmp("gray", 24'h0, bad);
        pwm_chk(24'h800100, 16000);
        pwm_chk(24'h980100, 20000);
        wreg(5'h1B, 24'h000100);
        cyc(1);
        cmp("pwm_off", 24'h0, poe);
        end_of_test();
    end
endmodule
